// ==== hw/irq_flag_enable_map.svh ====
`ifndef IRQ_FLAG_ENABLE_MAP_SVH
`define IRQ_FLAG_ENABLE_MAP_SVH

// register word addresses on the plain port
`define ADDR_FLAGS_THREE 4'h0
`define ADDR_FLAGS_FOUR 4'h1
`define ADDR_FLAGS_FIVE 4'h2
`define ADDR_ENABLES_ZERO 4'h3

// implemented-bit masks; every other bit reads zero and ignores writes
`define MASK_FLAGS_THREE 16'h4006
`define MASK_FLAGS_FOUR 16'h210E
`define MASK_FLAGS_FIVE 16'h0001
`define MASK_ENABLES_ZERO 16'hBFEF

// field positions in the flag registers
`define BIT_CALENDAR 14
`define BIT_I2C_B_MASTER 2
`define BIT_I2C_B_SLAVE 1
`define BIT_CHARGE_TIME 13
`define BIT_VOLT_DETECT 8
`define BIT_CHECKSUM 3
`define BIT_UART_B_ERR 2
`define BIT_UART_A_ERR 1
`define BIT_LOW_POWER_WAKE 0

// field positions in the enable register
`define BIT_NVM 15
`define BIT_CONV_DONE 13
`define BIT_UART_A_TX 12
`define BIT_UART_A_RX 11
`define BIT_SPI_A_DONE 10
`define BIT_SPI_A_FAULT 9
`define BIT_TIMER_C 8
`define BIT_TIMER_B 7
`define BIT_COMPARE_B 6
`define BIT_CAPTURE_B 5
`define BIT_TIMER_A 3
`define BIT_COMPARE_A 2
`define BIT_CAPTURE_A 1
`define BIT_EXT_PIN_ZERO 0

`define RESET_REG 16'h0000

`endif

// ==== hw/irq_flag_enable_pkg.sv ====
package irq_flag_enable_pkg;

    typedef logic [15:0] word_t;

    // register-port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // hardware set events, one strobe per flag bit
    typedef struct packed {
        logic calendar;
        logic i2cBMaster;
        logic i2cBSlave;
        logic chargeTime;
        logic voltDetect;
        logic checksum;
        logic uartBErr;
        logic uartAErr;
        logic lowPowerWake;
    } flag_events_t;

endpackage : irq_flag_enable_pkg

// ==== hw/irq_flag_enable_bank.sv ====
`timescale 1ns/100ps
`include "irq_flag_enable_map.svh"
// Overview of operation
// RL1 - flags three bit 14 sets on a calendar clock request
// RL2 - flags three bit 2 on I2C-B master, bit 1 on I2C-B slave
// RL3 - flags four bit 13 sets on charge-time unit request
// RL4 - flags four bit 8 sets on voltage detector request
// RL5 - flags four bit 3 sets on checksum unit request
// RL6 - flags four bit 2 on UART-B error, bit 1 on UART-A error
// RL7 - flags five bit 0 sets on low-power wake; bits 15..1 unused
// RL8 - a flag reads one after its request occurred, else zero
// RL9 - flags set by hardware, software read/write, cleared at reset
// RL10 - unimplemented bits read zero and ignore writes
// RL11 - enable zero bit 15 gates memory request; bit 14 unused
// RL12 - enable zero bit 13 gates conversion-done request
// RL13 - bit 12 gates UART-A transmit, bit 11 UART-A receive
// RL14 - bit 10 gates SPI-A done, bit 9 SPI-A fault
// RL15 - bits 8, 7, 3 gate timers C, B, A; bit 4 unused
// RL16 - bit 6 gates compare B, bit 5 capture B
// RL17 - bit 2 gates compare A, bit 1 capture A
// RL18 - bit 0 gates external pin zero request
// RL19 - enable one passes request, zero blocks; read/write, reset zero
// RL20 - request forwarded only while flag and enable both set; flagRequests here forwards the set flag alone, with no enable
// RL21 - hardware set wins over a same-cycle software clear
module irq_flag_enable_bank (
    input wire logic clk_sys, // system clock, 25 MHz
    input wire logic rst, // asynchronous reset, active high
    input irq_flag_enable_pkg::bus_req_t busReq, // register port request
    output irq_flag_enable_pkg::word_t rdData, // read data, cycle after read
    input irq_flag_enable_pkg::flag_events_t flagEvents, // flag set pulses
    input irq_flag_enable_pkg::word_t enableSources, // requests gated by enables
    output irq_flag_enable_pkg::word_t gatedRequests, // enabled requests
    output logic [8:0] flagRequests // set flags alone, no enable, event order
);
    import irq_flag_enable_pkg::*;

    //--------------------------------------------------------------
    // flag registers
    //--------------------------------------------------------------
    word_t flagsThree;
    word_t flagsFour;
    word_t flagsFive;
    word_t enablesZero;
    word_t setThree;
    word_t setFour;
    word_t setFive;
    word_t next_flagsThree;
    word_t next_flagsFour;
    word_t next_flagsFive;

    // event strobes placed at their bit positions
    always_comb begin
        setThree = 16'h0000;
        setFour = 16'h0000;
        setFive = 16'h0000;
        setThree[`BIT_CALENDAR] = flagEvents.calendar; // [RL1]
        setThree[`BIT_I2C_B_MASTER] = flagEvents.i2cBMaster; // [RL2]
        setThree[`BIT_I2C_B_SLAVE] = flagEvents.i2cBSlave; // [RL2]
        setFour[`BIT_CHARGE_TIME] = flagEvents.chargeTime; // [RL3]
        setFour[`BIT_VOLT_DETECT] = flagEvents.voltDetect; // [RL4]
        setFour[`BIT_CHECKSUM] = flagEvents.checksum; // [RL5]
        setFour[`BIT_UART_B_ERR] = flagEvents.uartBErr; // [RL6]
        setFour[`BIT_UART_A_ERR] = flagEvents.uartAErr; // [RL6]
        setFive[`BIT_LOW_POWER_WAKE] = flagEvents.lowPowerWake; // [RL7]
    end

    // a software write replaces the value, then hardware sets are OR-ed in last
    // so an event in the clearing cycle survives; masks keep unused bits at zero
    always_comb begin
        next_flagsThree = flagsThree;
        next_flagsFour = flagsFour;
        next_flagsFive = flagsFive;
        if (busReq.wr && busReq.addr == `ADDR_FLAGS_THREE) begin
            next_flagsThree = busReq.wdata; // [RL9]
        end else if (busReq.wr && busReq.addr == `ADDR_FLAGS_FOUR) begin
            next_flagsFour = busReq.wdata;
        end else if (busReq.wr && busReq.addr == `ADDR_FLAGS_FIVE) begin
            next_flagsFive = busReq.wdata;
        end
        next_flagsThree = (next_flagsThree | setThree) & `MASK_FLAGS_THREE; // [RL21] [RL10]
        next_flagsFour = (next_flagsFour | setFour) & `MASK_FLAGS_FOUR; // [RL21] [RL10]
        next_flagsFive = (next_flagsFive | setFive) & `MASK_FLAGS_FIVE; // [RL21] [RL10]
    end

    // flags hold until software clears them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flagsThree <= `RESET_REG; // [RL9]
            flagsFour <= `RESET_REG;
            flagsFive <= `RESET_REG;
        end else begin
            flagsThree <= next_flagsThree; // [RL8] [RL20]
            flagsFour <= next_flagsFour;
            flagsFive <= next_flagsFive;
        end
    end

    //--------------------------------------------------------------
    // enable register
    //--------------------------------------------------------------
    // only implemented enable bits store; bits 14 and 4 stay zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enablesZero <= `RESET_REG; // [RL19]
        end else if (busReq.wr && busReq.addr == `ADDR_ENABLES_ZERO) begin
            enablesZero <= busReq.wdata & `MASK_ENABLES_ZERO; // [RL11] [RL15] [RL10]
        end
    end

    //--------------------------------------------------------------
    // request outputs
    //--------------------------------------------------------------
    // registered so outputs leave flops; costs one cycle of latency
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gatedRequests <= 16'h0000;
            flagRequests <= 9'h000;
        end else begin
            // bit positions match enable fields 15..0
            gatedRequests <= enableSources & enablesZero; // [RL12] [RL13] [RL14] [RL16] [RL17] [RL18] [RL19]
            // no enables for these flags live here; forward the set flag itself
            flagRequests <= {flagsThree[`BIT_CALENDAR], flagsThree[`BIT_I2C_B_MASTER],
                flagsThree[`BIT_I2C_B_SLAVE], flagsFour[`BIT_CHARGE_TIME],
                flagsFour[`BIT_VOLT_DETECT], flagsFour[`BIT_CHECKSUM],
                flagsFour[`BIT_UART_B_ERR], flagsFour[`BIT_UART_A_ERR],
                flagsFive[`BIT_LOW_POWER_WAKE]}; // [RL20]
        end
    end

    //--------------------------------------------------------------
    // read port
    //--------------------------------------------------------------
    // data stands one cycle after the read strobe, zero otherwise or if unmapped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData <= 16'h0000;
        end else if (busReq.rd && busReq.addr == `ADDR_FLAGS_THREE) begin
            rdData <= flagsThree; // [RL8]
        end else if (busReq.rd && busReq.addr == `ADDR_FLAGS_FOUR) begin
            rdData <= flagsFour;
        end else if (busReq.rd && busReq.addr == `ADDR_FLAGS_FIVE) begin
            rdData <= flagsFive;
        end else if (busReq.rd && busReq.addr == `ADDR_ENABLES_ZERO) begin
            rdData <= enablesZero;
        end else begin
            rdData <= 16'h0000;
        end
    end

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    sequence s_calSet;
        flagEvents.calendar;
    endsequence

    a_calendar_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
        s_calSet |=> flagsThree[14]) else $error("calendar flag not set");
    a_i2c_master_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
        flagEvents.i2cBMaster |=> flagsThree[2]) else $error("i2c master flag not set");
    a_charge_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
        flagEvents.chargeTime |=> flagsFour[13]) else $error("charge flag not set");
    a_volt_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
        flagEvents.voltDetect |=> flagsFour[8]) else $error("voltage flag not set");
    a_checksum_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
        flagEvents.checksum |=> flagsFour[3]) else $error("checksum flag not set");
    a_uart_err_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
        flagEvents.uartAErr |=> flagsFour[1]) else $error("uart error flag not set");
    a_five_unused_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
        flagsFive[15:1] == 15'h0000) else $error("unused flag bits nonzero");
    a_unused_bits_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        (enablesZero[14] == 1'b0) && (enablesZero[4] == 1'b0)
        && ((flagsFour & ~`MASK_FLAGS_FOUR) == 16'h0000)) else $error("unused bit set");
    a_flag_holds: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
        (flagsThree[14] && !busReq.wr) |=> flagsThree[14]) else $error("flag dropped");
    a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RL21]
        (busReq.wr && busReq.addr == `ADDR_FLAGS_FOUR && flagEvents.checksum)
        |=> flagsFour[3]) else $error("set lost to clear");
    a_enable_gates: assert property (@(posedge clk_sys) disable iff (rst) // [RL19]
        (enableSources[0] && !enablesZero[0]) |=> !gatedRequests[0])
        else $error("blocked request passed");
    a_read_latency: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
        (busReq.rd && busReq.addr == `ADDR_ENABLES_ZERO && !busReq.wr)
        |=> rdData == $past(enablesZero)) else $error("read data wrong");

    //--------------------------------------------------------------
    // helper views for the checks
    //--------------------------------------------------------------
    // the nine event-driven flags by name; checks only, no output uses them
    wire calendarEventFlag = flagsThree[`BIT_CALENDAR];
    wire i2cBMasterEventFlag = flagsThree[`BIT_I2C_B_MASTER];
    wire i2cBSlaveEventFlag = flagsThree[`BIT_I2C_B_SLAVE];
    wire chargeTimeUnitFlag = flagsFour[`BIT_CHARGE_TIME];
    wire voltageDetectFlag = flagsFour[`BIT_VOLT_DETECT];
    wire checksumUnitFlag = flagsFour[`BIT_CHECKSUM];
    wire uartBErrorFlag = flagsFour[`BIT_UART_B_ERR];
    wire uartAErrorFlag = flagsFour[`BIT_UART_A_ERR];
    wire lowPowerWakeFlag = flagsFive[`BIT_LOW_POWER_WAKE];
    // the same nine as a vector, in flagRequests order
    logic [8:0] flagNine;
    // the nine event strobes as one vector, same order
    logic [8:0] evVec;
    // all three flag words side by side, for per-bit hold checks
    logic [47:0] allFlags;

    assign flagNine = {calendarEventFlag, i2cBMasterEventFlag, i2cBSlaveEventFlag,
        chargeTimeUnitFlag, voltageDetectFlag, checksumUnitFlag, uartBErrorFlag,
        uartAErrorFlag, lowPowerWakeFlag};
    assign evVec = flagEvents;
    assign allFlags = {flagsFive, flagsFour, flagsThree};

    //--------------------------------------------------------------
    // register-port steps
    //--------------------------------------------------------------
    // quiet writes: no event races them, so the stored word is exact
    sequence s_quietWrThree;
        busReq.wr && busReq.addr == `ADDR_FLAGS_THREE && !flagEvents.calendar
            && !flagEvents.i2cBMaster && !flagEvents.i2cBSlave;
    endsequence

    sequence s_quietWrFour;
        busReq.wr && busReq.addr == `ADDR_FLAGS_FOUR && !flagEvents.chargeTime
            && !flagEvents.voltDetect && !flagEvents.checksum
            && !flagEvents.uartBErr && !flagEvents.uartAErr;
    endsequence

    sequence s_quietWrFive;
        busReq.wr && busReq.addr == `ADDR_FLAGS_FIVE && !flagEvents.lowPowerWake;
    endsequence

    // no enable is hardware settable, so enable writes never race
    sequence s_wrEnable;
        busReq.wr && busReq.addr == `ADDR_ENABLES_ZERO;
    endsequence

    // a clearing write meets a calendar event in the same cycle
    sequence s_calClearRace;
        busReq.wr && busReq.addr == `ADDR_FLAGS_THREE && flagEvents.calendar;
    endsequence

    // the same race on flags four, with a checksum event
    sequence s_sumClearRace;
        busReq.wr && busReq.addr == `ADDR_FLAGS_FOUR && flagEvents.checksum;
    endsequence

    // read strobes, one per mapped word
    sequence s_rdThree;
        busReq.rd && busReq.addr == `ADDR_FLAGS_THREE;
    endsequence

    sequence s_rdFour;
        busReq.rd && busReq.addr == `ADDR_FLAGS_FOUR;
    endsequence

    sequence s_rdFive;
        busReq.rd && busReq.addr == `ADDR_FLAGS_FIVE;
    endsequence

    sequence s_rdEnable;
        busReq.rd && busReq.addr == `ADDR_ENABLES_ZERO;
    endsequence

    // addresses past the last register decode to nothing
    sequence s_rdUnmapped;
        busReq.rd && busReq.addr > `ADDR_ENABLES_ZERO;
    endsequence

    // a read, then a cycle with no read: the data must not linger
    sequence s_rdThenIdle;
        busReq.rd ##1 !busReq.rd;
    endsequence

    //--------------------------------------------------------------
    // further flag checks
    //--------------------------------------------------------------
    // events the first group leaves out
    a_slave_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
        flagEvents.i2cBSlave |=> i2cBSlaveEventFlag) else $error("i2c slave flag not set");
    a_uart_b_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
        flagEvents.uartBErr |=> uartBErrorFlag) else $error("uart b error flag not set");
    a_wake_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
        flagEvents.lowPowerWake |=> lowPowerWakeFlag) else $error("wake flag not set");
    // unused positions of flags three stay clear
    a_three_unused_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        (flagsThree & ~`MASK_FLAGS_THREE) == 16'h0000) else $error("unused flag bit set");
    // without an event or a write no flag moves
    a_flags_stay_put: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
        (evVec == 9'h000 && !busReq.wr) |=> $stable(allFlags)) else $error("flag moved");
    // a clearing write loses to the event it meets
    a_race_calendar_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL21]
        s_calClearRace |=> calendarEventFlag) else $error("calendar set lost to clear");
    a_race_checksum_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL21]
        s_sumClearRace |=> checksumUnitFlag) else $error("checksum set lost to clear");

    //--------------------------------------------------------------
    // register-port checks
    //--------------------------------------------------------------
    // a quiet write stores exactly its implemented bits
    a_write_three_lands: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
        s_quietWrThree |=> flagsThree == ($past(busReq.wdata) & `MASK_FLAGS_THREE))
        else $error("flags three write lost");
    // flags four: same, every event of the word held off
    a_write_four_lands: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
        s_quietWrFour |=> flagsFour == ($past(busReq.wdata) & `MASK_FLAGS_FOUR))
        else $error("flags four write lost");
    // flags five keeps only its single wake bit
    a_write_five_lands: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
        s_quietWrFive |=> flagsFive == ($past(busReq.wdata) & `MASK_FLAGS_FIVE))
        else $error("flags five write lost");
    // enable writes land, and nothing else moves the enables
    a_enable_write_lands: assert property (@(posedge clk_sys) disable iff (rst) // [RL19]
        s_wrEnable |=> enablesZero == ($past(busReq.wdata) & `MASK_ENABLES_ZERO))
        else $error("enable write lost");
    // writes to other words must leave the enables alone
    a_enable_holds: assert property (@(posedge clk_sys) disable iff (rst) // [RL19]
        !(busReq.wr && busReq.addr == `ADDR_ENABLES_ZERO) |=> $stable(enablesZero))
        else $error("enables moved without a write");
    // unused enable positions never store a one
    a_enable_unused_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL11] [RL15]
        (enablesZero & ~`MASK_ENABLES_ZERO) == 16'h0000) else $error("unused enable set");
    // each read returns the word as it stood at the strobe
    a_read_three: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
        s_rdThree |=> rdData == $past(flagsThree)) else $error("flags three read wrong");
    // the checksum, voltage and uart flags come back through word four
    a_read_four: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
        s_rdFour |=> rdData == $past(flagsFour)) else $error("flags four read wrong");
    // the wake flag comes back through word five
    a_read_five: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
        s_rdFive |=> rdData == $past(flagsFive)) else $error("flags five read wrong");
    // the enable word never shows its unused bits
    a_read_enable_masked: assert property (@(posedge clk_sys) disable iff (rst) // [RL11] [RL15]
        s_rdEnable |=> (rdData & ~`MASK_ENABLES_ZERO) == 16'h0000)
        else $error("enable read shows unused bit");
    // unmapped reads give zero
    a_read_unmapped: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        s_rdUnmapped |=> rdData == 16'h0000) else $error("unmapped read not zero");
    // no read data outlives its cycle
    a_read_falls_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        s_rdThenIdle |=> rdData == 16'h0000) else $error("read data lingered");

    //--------------------------------------------------------------
    // per-bit checks
    //--------------------------------------------------------------
    // every flag bit stays set until software writes a word
    for (genvar g = 0; g < 48; g++) begin : g_flagHold
        a_flag_bit_holds: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
            (allFlags[g] && !busReq.wr) |=> allFlags[g]) else $error("flag bit dropped");
    end

    // each event reaches its request two cycles on; a request needs its flag
    for (genvar g = 0; g < 9; g++) begin : g_evRequest
        a_event_to_request: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
            evVec[g] |-> ##2 flagRequests[g]) else $error("event not forwarded");
        a_request_follows: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
            1'b1 |=> flagRequests[g] == $past(flagNine[g])) else $error("request not flag");
    end

    // no flag, no request
    a_requests_quiet: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
        (flagNine == 9'h000) |=> flagRequests == 9'h000) else $error("stray request");

    // an enabled source passes a cycle later; a blocked one never does
    for (genvar g = 0; g < 16; g++) begin : g_gate
        a_gate_pass: assert property (@(posedge clk_sys) disable iff (rst) // [RL19]
            (enableSources[g] && enablesZero[g]) |=> gatedRequests[g])
            else $error("enabled request blocked");
        a_gate_block: assert property (@(posedge clk_sys) disable iff (rst) // [RL19]
            !enablesZero[g] |=> !gatedRequests[g]) else $error("blocked request passed");
    end

    // silent sources give silent outputs, whatever the enables hold
    a_gated_quiet: assert property (@(posedge clk_sys) disable iff (rst) // [RL19]
        (enableSources == 16'h0000) |=> gatedRequests == 16'h0000) else $error("stray gate");
    // unused enable positions never pass a request
    a_gate_unused_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL11] [RL15]
        !gatedRequests[14] && !gatedRequests[4]) else $error("unused enable passed");

endmodule : irq_flag_enable_bank

// ==== verif/periph_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// peripheral side: event strobes and request levels
// ----------------------------------------
module periph_model (
    input wire logic clk_sys, // system clock
    input wire logic rst, // reset, active high
    input irq_flag_enable_pkg::flag_events_t evReq, // events the bench wants raised
    input irq_flag_enable_pkg::word_t srcReq, // request levels the bench wants held
    output irq_flag_enable_pkg::flag_events_t flagEvents, // event strobes to the bank
    output irq_flag_enable_pkg::word_t enableSources // raw request levels to the bank
);
    import irq_flag_enable_pkg::*;
    // outputs move only just after an edge, so the bank never sees a mid-cycle glitch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flagEvents <= '0;
            enableSources <= '0;
        end else begin
            flagEvents <= evReq;
            enableSources <= srcReq;
        end
    end
endmodule : periph_model

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`include "irq_flag_enable_map.svh"
module tb;
    import irq_flag_enable_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    bus_req_t busReq = '0;
    word_t rdData, enableSources, gatedRequests, srcReq = '0, en = '0, src = '0;
    flag_events_t flagEvents, evReq = '0;
    logic [8:0] flagRequests;
    int errors = 0;
    int testsRun = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h10;
    // register and bit of each event, in event order; addr 7 is unmapped
    logic [3:0] evAddr [9] = '{4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
    int evBit [9] = '{0, 1, 2, 3, 8, 13, 1, 2, 14};
    logic [3:0] addrOf [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7};
    word_t maskOf [5] = '{`MASK_FLAGS_THREE, `MASK_FLAGS_FOUR, `MASK_FLAGS_FIVE,
        `MASK_ENABLES_ZERO, 16'h0000};

    periph_model periph_model_i (.clk_sys(clk_sys), .rst(rst), .evReq(evReq),
        .srcReq(srcReq), .flagEvents(flagEvents), .enableSources(enableSources));
    irq_flag_enable_bank irq_flag_enable_bank_i (.clk_sys(clk_sys), .rst(rst),
        .busReq(busReq), .rdData(rdData), .flagEvents(flagEvents),
        .enableSources(enableSources), .gatedRequests(gatedRequests),
        .flagRequests(flagRequests));

    // ----------------------------------------
    // clock, hang guard, helpers
    // ----------------------------------------
    always #20 clk_sys = ~clk_sys;
    // the sequence needs under two thousand cycles; a hang ends the run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic word_t gate(input word_t e, input word_t s);
        return s & e & `MASK_ENABLES_ZERO;
    endfunction : gate
    task automatic chk(input word_t seen, input word_t exp);
        testsRun = testsRun + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input word_t d);
        @(posedge clk_sys);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        busReq <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input word_t exp);
        @(posedge clk_sys);
        busReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        busReq <= '0;
        #1 chk(rdData, exp);
    endtask : rchk
    task automatic fire(input flag_events_t ev);
        @(posedge clk_sys);
        evReq <= ev;
        @(posedge clk_sys);
        evReq <= '0;
    endtask : fire
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        // everything reads zero out of reset, unmapped place too
        for (int a = 0; a < 5; a++) rchk(addrOf[a], 16'h0000);
        // all-ones writes keep only implemented bits; the unmapped write is dropped
        for (int a = 0; a < 5; a++) wr(addrOf[a], 16'hFFFF);
        for (int a = 0; a < 5; a++) rchk(addrOf[a], maskOf[a]);
        for (int a = 0; a < 4; a++) wr(addrOf[a], 16'h0000);
        // each event sets its own bit, holds it, and software clears it
        for (int i = 0; i < 9; i++) begin
            fire(flag_events_t'(9'h001 << i));
            repeat (6) @(posedge clk_sys);
            #1 chk(word_t'(flagRequests), word_t'(9'h001 << i));
            rchk(evAddr[i], 16'h0001 << evBit[i]);
            wr(evAddr[i], 16'h0000);
            rchk(evAddr[i], 16'h0000);
        end
        // event and clearing write land on the same edge: the event survives
        // first the calendar flag in word zero, then the checksum flag in word one
        for (int k = 0; k < 2; k++) begin
            fork
                fire((k == 0) ? 9'h100 : 9'h008);
                begin
                    @(posedge clk_sys);
                    wr(4'(k), 16'h0000);
                end
            join
            rchk(4'(k), (k == 0) ? 16'h4000 : 16'h0008);
            wr(4'(k), 16'h0000);
        end
        // random enables and requests, with all-on and all-off corners first
        for (int n = 0; n < 40; n++) begin
            en = word_t'(xs());
            src = word_t'(xs());
            if (n < 2) begin
                en = (n == 0) ? 16'hFFFF : 16'h0000;
                src = 16'hFFFF;
            end
            wr(4'h3, en);
            srcReq <= src;
            repeat (4) @(posedge clk_sys);
            #1 chk(gatedRequests, gate(en, src));
            rchk(4'h3, en & `MASK_ENABLES_ZERO);
            @(posedge clk_sys);
            #1 chk(rdData, 16'h0000);
        end
        print_verdict();
    end
endmodule : tb
